// >>> verilog/fdp_fractional_loop.sv
`timescale 1ns/1ps
module fdp_fractional_loop #(
    parameter int                       MULT_INT_BITS = fdp_pkg::MULT_INT_W,
    parameter logic [fdp_pkg::LTMR_W-1:0] TIMEOUT_TICKS = fdp_pkg::LOCK_TIMEOUT
) (
    // Clock and reset
    input  wire logic                               clk,
    input  wire logic                               reset_n,
    // Reference sources
    input  wire logic                               external_32k_oscillator,
    input  wire logic                               external_crystal_oscillator,
    input  wire logic                               generic_reference_channel,
    input  wire logic                               lock_timer_clock,
    // Configuration
    input  wire logic                               loop_enable,
    input  wire fdp_pkg::fdp_ref_sel_e              ref_select,
    input  wire logic [fdp_pkg::DIV_W-1:0]          crystal_divide,
    input  wire logic [fdp_pkg::MULT_INT_W-1:0]     mult_integer,
    input  wire logic [fdp_pkg::MULT_FRAC_W-1:0]    mult_fraction,
    input  wire logic                               lock_timer_use,
    input  wire logic                               test_open_loop,
    // Event flags and enables
    input  wire logic [2:0]                         flag_clear,
    input  wire logic [2:0]                         irq_enable_set,
    input  wire logic [2:0]                         irq_enable_clear,
    // Outputs
    output logic                                    pll_output_clock,
    output logic                                    pll_reference_clock,
    output logic                                    lock_status,
    output logic [2:0]                              event_flags,
    output logic [2:0]                              irq_enables,
    output logic [2:0]                              event_request
);
    import fdp_pkg::*;

    logic                rst_meta_r;
    logic                rst_sync_r;
    logic                x32_r;
    logic                xtal_r;
    logic                gref_r;
    logic                lt_r;
    logic [DIV_W-1:0]    div_cnt_r;
    logic                xdiv_r;
    logic                ref_level;
    logic                ref_r;
    logic                en_r;
    logic [HIT_W-1:0]    hits_r;
    logic                locked_r;
    logic                locked_nxt;
    logic [LTMR_W-1:0]   ltmr_r;
    logic                timed_out_r;
    logic                timeout_evt;
    logic [2:0]          set_evt;
    logic [2:0]          flags_r;
    logic [2:0]          ien_r;
    logic                gate_r;
    logic                out_r;

    fdp_core_if cif ();

    // Reset release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // Previous input levels for edge detection
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            x32_r  <= 1'b0;
            xtal_r <= 1'b0;
            gref_r <= 1'b0;
            lt_r   <= 1'b0;
        end else begin
            x32_r  <= external_32k_oscillator;
            xtal_r <= external_crystal_oscillator;
            gref_r <= generic_reference_channel;
            lt_r   <= lock_timer_clock;
        end
    end

    // Crystal divider: output period is 2*(crystal_divide+1) crystal periods
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            div_cnt_r <= '0;
            xdiv_r    <= 1'b0;
        end else if (external_crystal_oscillator && !xtal_r) begin
            if (div_cnt_r >= crystal_divide) begin
                div_cnt_r <= '0;
                xdiv_r    <= !xdiv_r;
            end else begin
                div_cnt_r <= div_cnt_r + DIV_W'(1);
            end
        end
    end

    // Reference input multiplexer
    always_comb begin
        case (ref_select)
            FDP_REF_32K:  ref_level = x32_r;
            FDP_REF_XTAL: ref_level = xdiv_r;
            FDP_REF_GCLK: ref_level = gref_r;
            default:      ref_level = x32_r;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ref_r <= 1'b0;
            en_r  <= 1'b0;
        end else begin
            ref_r <= ref_level;
            en_r  <= loop_enable;
        end
    end

    // Controller to core
    assign cif.enable   = en_r;
    assign cif.mult_q   = {mult_integer, mult_fraction};
    assign cif.ref_edge = ref_level && !ref_r && en_r;

    fdp_loop_core u_core (
        .clk   (clk),
        .rst_n (rst_sync_r),
        .cif   (cif)
    );

    // Lock detection from consecutive small phase errors
    always_comb begin
        locked_nxt = locked_r;
        if (!en_r) begin
            locked_nxt = 1'b0;
        end else if (cif.err_valid) begin
            if (fdp_abs(cif.err) > LOCK_TOL) begin
                locked_nxt = 1'b0;
            end else if (hits_r >= LOCK_HITS - HIT_W'(1)) begin
                locked_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            hits_r   <= '0;
            locked_r <= 1'b0;
        end else begin
            locked_r <= locked_nxt;
            if (!en_r) begin
                hits_r <= '0;
            end else if (cif.err_valid) begin
                if (fdp_abs(cif.err) > LOCK_TOL) begin
                    hits_r <= '0;
                end else if (hits_r < LOCK_HITS) begin
                    hits_r <= hits_r + HIT_W'(1);
                end
            end
        end
    end

    // Lock timer on the lock timer clock edges
    assign timeout_evt = en_r && lock_timer_use && !locked_r && !timed_out_r
                       && lock_timer_clock && !lt_r
                       && (ltmr_r >= TIMEOUT_TICKS - LTMR_W'(1));

    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ltmr_r      <= '0;
            timed_out_r <= 1'b0;
        end else if (!en_r || !lock_timer_use || locked_r) begin
            ltmr_r      <= '0;
            timed_out_r <= 1'b0;
        end else if (timeout_evt) begin
            timed_out_r <= 1'b1;
        end else if (lock_timer_clock && !lt_r && !timed_out_r) begin
            ltmr_r <= ltmr_r + LTMR_W'(1);
        end
    end

    // Event flags: a new event wins over a clear
    always_comb begin
        set_evt              = '0;
        set_evt[FLG_TIMEOUT] = timeout_evt;
        set_evt[FLG_FALL]    = locked_r && !locked_nxt;
        set_evt[FLG_RISE]    = !locked_r && locked_nxt;
    end

    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            flags_r <= FLAGS_RESET;
        end else begin
            flags_r <= (flags_r & ~flag_clear) | set_evt;
        end
    end

    // Interrupt enables: clear position disables
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            ien_r <= IEN_RESET;
        end else begin
            ien_r <= (ien_r | irq_enable_set) & ~irq_enable_clear;
        end
    end

    // Final output gate, passes the core oscillator level while enabled and either locked or in open-loop test
    always_ff @(posedge clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            gate_r <= 1'b0;
            out_r  <= 1'b0;
        end else begin
            gate_r <= en_r && (locked_r || test_open_loop);
            out_r  <= gate_r && en_r && cif.osc_level;
        end
    end

    assign pll_output_clock    = out_r;
    assign pll_reference_clock = ref_r;
    assign lock_status         = locked_r;
    assign event_flags         = flags_r;
    assign irq_enables         = ien_r;
    assign event_request       = flags_r & ien_r;

endmodule

// >>> verilog/fdp_pkg.sv
package fdp_pkg;

    // Clock and timing
    localparam int CLK_HZ        = 100_000_000;
    localparam int LOCK_TIMER_HZ = 32_768;

    // Widths
    localparam int ACC_W       = 24;
    localparam int PHASE_W     = 40;
    localparam int MULT_INT_W  = 12;
    localparam int MULT_FRAC_W = 4;
    localparam int MULT_W      = MULT_INT_W + MULT_FRAC_W;
    localparam int ERR_W       = 21;
    localparam int TUNE_W      = 32;
    localparam int DIV_W       = 8;
    localparam int HIT_W       = 8;
    localparam int LTMR_W      = 16;

    // Loop filter shifts and start value
    localparam int                 KP_SH     = 12;
    localparam int                 KI_SH     = 6;
    localparam logic [TUNE_W-1:0]  TUNE_INIT = 32'h0010_0000;
    localparam logic [TUNE_W-1:0]  TUNE_MAX  = 32'h0080_0000;

    // Lock detection
    localparam logic [ERR_W-1:0]   LOCK_TOL     = 21'h00_0010;
    localparam logic [HIT_W-1:0]   LOCK_HITS    = 8'h08;
    localparam logic [LTMR_W-1:0]  LOCK_TIMEOUT = 16'h0100;

    // Reset values
    localparam logic [2:0]         FLAGS_RESET  = 3'h0;
    localparam logic [2:0]         IEN_RESET    = 3'h0;

    // Event flag positions
    localparam int FLG_TIMEOUT = 0;
    localparam int FLG_FALL    = 1;
    localparam int FLG_RISE    = 2;

    typedef enum logic [1:0] {
        FDP_REF_32K,
        FDP_REF_XTAL,
        FDP_REF_GCLK
    } fdp_ref_sel_e;

    typedef logic signed [ERR_W-1:0]  fdp_err_t;
    typedef logic signed [TUNE_W-1:0] fdp_tune_t;

    function automatic fdp_tune_t fdp_scale(input fdp_err_t e, input int sh);
        fdp_tune_t w;
        w = {{(TUNE_W-ERR_W){e[ERR_W-1]}}, e};
        return w <<< sh;
    endfunction

    function automatic logic [ERR_W-1:0] fdp_abs(input fdp_err_t e);
        return e[ERR_W-1] ? ERR_W'(-e) : ERR_W'(e);
    endfunction

endpackage

// >>> verilog/fdp_core_if.sv
`timescale 1ns/1ps
interface fdp_core_if;
    import fdp_pkg::*;
    logic                enable;
    logic [MULT_W-1:0]   mult_q;
    logic                ref_edge;
    fdp_err_t            err;
    logic                err_valid;
    logic                osc_level;

    modport ctrl (output enable, output mult_q, output ref_edge,
                  input err, input err_valid, input osc_level);
    modport core (input enable, input mult_q, input ref_edge,
                  output err, output err_valid, output osc_level);
endinterface

// >>> verilog/fdp_loop_core.sv
`timescale 1ns/1ps
module fdp_loop_core (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst_n,
    // Controller side
    fdp_core_if.core   cif
);
    import fdp_pkg::*;

    logic [PHASE_W-1:0] phase_r;
    logic [PHASE_W-1:0] last_r;
    logic               primed_r;
    fdp_tune_t          integ_r;
    fdp_tune_t          tune_r;
    fdp_err_t           err_r;
    logic               err_valid_r;
    logic [PHASE_W-1:0] diff;
    fdp_err_t           err_nxt;
    fdp_tune_t          integ_nxt;
    fdp_tune_t          tune_nxt;

    // Phase time converter: output cycles per reference period in 1/16 units
    always_comb begin
        diff      = phase_r - last_r;
        err_nxt   = fdp_err_t'({5'h00, cif.mult_q})
                  - fdp_err_t'({1'b0, diff[PHASE_W-1:ACC_W-MULT_FRAC_W]});
        integ_nxt = integ_r + fdp_scale(err_nxt, KI_SH);
        // Integrator held in range so a long unlock cannot wrap it
        if (integ_nxt < 0) begin
            integ_nxt = '0;
        end else if (integ_nxt > fdp_tune_t'(TUNE_MAX)) begin
            integ_nxt = fdp_tune_t'(TUNE_MAX);
        end
        tune_nxt  = integ_nxt + fdp_scale(err_nxt, KP_SH);
        if (tune_nxt < 0) begin
            tune_nxt = '0;
        end else if (tune_nxt > fdp_tune_t'(TUNE_MAX)) begin
            tune_nxt = fdp_tune_t'(TUNE_MAX);
        end
    end

    // Controlled oscillator as phase accumulator
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= '0;
        end else if (!cif.enable) begin
            phase_r <= '0;
        end else begin
            phase_r <= phase_r + PHASE_W'(unsigned'(tune_r));
        end
    end

    // Reference edge capture
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_r   <= '0;
            primed_r <= 1'b0;
        end else if (!cif.enable) begin
            last_r   <= '0;
            primed_r <= 1'b0;
        end else if (cif.ref_edge) begin
            last_r   <= phase_r;
            primed_r <= 1'b1;
        end
    end

    // Proportional-integral filter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            integ_r     <= fdp_tune_t'(TUNE_INIT);
            tune_r      <= fdp_tune_t'(TUNE_INIT);
            err_r       <= '0;
            err_valid_r <= 1'b0;
        end else if (!cif.enable) begin
            integ_r     <= fdp_tune_t'(TUNE_INIT);
            tune_r      <= fdp_tune_t'(TUNE_INIT);
            err_r       <= '0;
            err_valid_r <= 1'b0;
        end else begin
            err_valid_r <= cif.ref_edge && primed_r;
            if (cif.ref_edge && primed_r) begin
                integ_r <= integ_nxt;
                tune_r  <= tune_nxt;
                err_r   <= err_nxt;
            end
        end
    end

    assign cif.err       = err_r;
    assign cif.err_valid = err_valid_r;
    assign cif.osc_level = phase_r[ACC_W-1];

endmodule

// >>> dv/fdp_monitor.sv
`timescale 1ns/1ps
module fdp_monitor import fdp_pkg::*; #(
    parameter int                         MULT_INT_BITS = fdp_pkg::MULT_INT_W,
    parameter logic [fdp_pkg::LTMR_W-1:0] TIMEOUT_TICKS = fdp_pkg::LOCK_TIMEOUT
) (
    // Clock, reset, sources
    input wire logic                  clk,
    input wire logic                  reset_n,
    input wire logic                  external_32k_oscillator,
    input wire logic                  external_crystal_oscillator,
    input wire logic                  generic_reference_channel,
    input wire logic                  lock_timer_clock,
    // Configuration
    input wire logic                  loop_enable,
    input wire fdp_pkg::fdp_ref_sel_e ref_select,
    input wire logic [7:0]            crystal_divide,
    input wire logic [11:0]           mult_integer,
    input wire logic [3:0]            mult_fraction,
    input wire logic                  lock_timer_use,
    input wire logic                  test_open_loop,
    input wire logic [2:0]            flag_clear,
    input wire logic [2:0]            irq_enable_set,
    input wire logic [2:0]            irq_enable_clear,
    // Outputs
    input wire logic                  pll_output_clock,
    input wire logic                  pll_reference_clock,
    input wire logic                  lock_status,
    input wire logic [2:0]            event_flags,
    input wire logic [2:0]            irq_enables,
    input wire logic [2:0]            event_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    logic [2:0] set_r;
    logic [2:0] clr_r;

    // Enable pulses one cycle back
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            set_r <= 3'h0;
            clr_r <= 3'h0;
        end else begin
            set_r <= irq_enable_set & ~irq_enable_clear;
            clr_r <= irq_enable_clear;
        end
    end

    a_gate_off_closed:
        assert property (!loop_enable [*6] |-> !pll_output_clock)
        else $error("output clock while disabled");
    a_lock_off_low:
        assert property (!loop_enable [*4] |-> !lock_status)
        else $error("lock while disabled");
    a_rise_flag_set:
        assert property ($rose(lock_status) |-> event_flags[FLG_RISE])
        else $error("rise flag missing");
    a_fall_flag_set:
        assert property ($fell(lock_status) && loop_enable |-> ##[0:1] event_flags[FLG_FALL])
        else $error("fall flag missing");
    a_request_and:
        assert property (event_request == (event_flags & irq_enables))
        else $error("request mismatch");
    a_ien_clear_wins:
        assert property (|clr_r |-> (irq_enables & clr_r) == 3'h0)
        else $error("enable not cleared");
    a_ien_set_takes:
        assert property (|set_r |-> (irq_enables & set_r) == set_r)
        else $error("enable not set");
    a_flags_sticky:
        assert property ((($past(event_flags) & ~$past(flag_clear) & ~$past(flag_clear, 2))
            & ~event_flags) == 3'h0)
        else $error("flag dropped");
    a_timeout_cause:
        assert property ($rose(event_flags[FLG_TIMEOUT]) |-> $past(lock_timer_use) && !lock_status)
        else $error("timeout without timer");

    c_lock: cover property ($rose(lock_status));
    c_fall: cover property ($rose(event_flags[FLG_FALL]));
    c_timeout: cover property ($rose(event_flags[FLG_TIMEOUT]));
endmodule

bind fdp_fractional_loop fdp_monitor #(
    .MULT_INT_BITS(MULT_INT_BITS),
    .TIMEOUT_TICKS(TIMEOUT_TICKS)
) fdp_monitor_i (.*);

// >>> dv/fdp_ref_model.sv
`timescale 1ns/1ps
module fdp_ref_model #(
    parameter int H32 = 100,
    parameter int HXT = 3,
    parameter int HGC = 100,
    parameter int HLT = 20
) (
    // Control
    input  wire logic clk,
    input  wire logic run,
    input  wire logic slow,
    // Source levels
    output logic      external_32k_oscillator,
    output logic      external_crystal_oscillator,
    output logic      generic_reference_channel,
    output logic      lock_timer_clock
);
    logic [3:0] lvl = 4'h0;
    int         cnt [4] = '{default: 0};

    function automatic int lim(input int i);
        return i == 0 ? H32 : i == 1 ? HXT : i == 3 ? HLT : slow ? 2 * HGC : HGC;
    endfunction

    // Sources run before and while the loop is enabled
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (!run) begin
                cnt[i] <= 0;
                lvl[i] <= 1'b0;
            end else if (cnt[i] >= lim(i) - 1) begin
                cnt[i] <= 0;
                lvl[i] <= ~lvl[i];
            end else begin
                cnt[i] <= cnt[i] + 1;
            end
        end
    end

    assign {lock_timer_clock, generic_reference_channel} = lvl[3:2];
    assign {external_crystal_oscillator, external_32k_oscillator} = lvl[1:0];
endmodule

// >>> dv/fractional_dpll_control_tb.sv
`timescale 1ns/1ps
module fractional_dpll_control_tb;
    import fdp_pkg::*;
    localparam int H32 = 100;
    localparam int HXT = 3;
    localparam int HGC = 100;
    localparam int HLT = 20;

    logic             clk = 1'b0;
    logic             reset_n = 1'b0;
    logic             run = 1'b0;
    logic             slow = 1'b0;
    logic             loop_enable = 1'b0;
    logic             lock_timer_use = 1'b0;
    logic             test_open_loop = 1'b0;
    fdp_ref_sel_e     ref_select = FDP_REF_32K;
    logic [7:0]       crystal_divide = 8'h00;
    logic [11:0]      mult_integer = 12'h00C;
    logic [3:0]       mult_fraction = 4'h8;
    logic [2:0]       flag_clear = 3'h0;
    logic [2:0]       irq_enable_set = 3'h0;
    logic [2:0]       irq_enable_clear = 3'h0;
    logic             external_32k_oscillator, external_crystal_oscillator;
    logic             generic_reference_channel, lock_timer_clock;
    logic             pll_output_clock, pll_reference_clock, lock_status;
    logic [2:0]       event_flags, irq_enables, event_request;
    int               fails = 0;
    int               comparisons = 0;

    fdp_ref_model #(.H32(H32), .HXT(HXT), .HGC(HGC), .HLT(HLT)) fdp_ref_model_i (.*);
    fdp_fractional_loop #(.TIMEOUT_TICKS(16'h0004)) fdp_fractional_loop_i (.*);

    initial begin
        forever #5 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask

    task automatic ref_rise(output int k);
        logic p;
        p = pll_reference_clock;
        for (k = 1; k < 4000; k++) begin
            @(posedge clk);
            if (!p && pll_reference_clock) break;
            p = pll_reference_clock;
        end
    endtask

    task automatic out_rises(input int n, output int r);
        logic p;
        p = pll_output_clock;
        r = 0;
        repeat (n) begin
            @(posedge clk);
            r += int'(!p && pll_output_clock);
            p = pll_output_clock;
        end
    endtask

    task automatic wait_lock(input logic v, input int n);
        for (int i = 0; i < n && lock_status !== v; i++) @(posedge clk);
    endtask

    task automatic start(input fdp_ref_sel_e s, input logic [7:0] d, input logic [11:0] m);
        loop_enable <= 1'b0;
        cyc(3);
        ref_select <= s;
        crystal_divide <= d;
        mult_integer <= m;
        cyc(2);
        loop_enable <= 1'b1;
        cyc(1);
    endtask

    task automatic t_reset();
        check(event_flags, FLAGS_RESET, "flags");
        check(irq_enables, IEN_RESET, "enables");
        check({pll_output_clock, lock_status}, 2'h0, "outputs");
    endtask

    task automatic t_refs();
        int           k;
        fdp_ref_sel_e s [4] = '{FDP_REF_32K, FDP_REF_XTAL, FDP_REF_XTAL, FDP_REF_GCLK};
        logic [7:0]   d [4] = '{8'h00, 8'h00, 8'h05, 8'h00};
        int           e [4] = '{2 * H32, 4 * HXT, 24 * HXT, 2 * HGC};
        for (int i = 0; i < 4; i++) begin
            start(s[i], d[i], 12'h00C);
            ref_rise(k);
            ref_rise(k);
            check(16'(k), 16'(e[i]), "ref period");
        end
    endtask

    task automatic t_gate();
        int r;
        loop_enable <= 1'b0;
        test_open_loop <= 1'b1;
        cyc(6);
        out_rises(300, r);
        check(16'(r), 16'h0, "gate while off");
        loop_enable <= 1'b1;
        out_rises(300, r);
        check(16'(r != 0), 16'h1, "open loop output");
        loop_enable <= 1'b0;
        test_open_loop <= 1'b0;
        cyc(6);
    endtask

    task automatic t_lock();
        int r;
        irq_enable_set <= 3'h7;
        cyc(1);
        irq_enable_set <= 3'h0;
        start(FDP_REF_GCLK, 8'h00, 12'h00C);
        wait_lock(1'b1, 50000);
        check(lock_status, 1'b1, "lock");
        check(event_flags[FLG_RISE], 1'b1, "rise flag");
        check(event_request, 3'h4, "rise request");
        cyc(4);
        out_rises(8 * HGC, r);
        check(16'(r >= 48 && r <= 52), 16'h1, "ratio 12.5");
    endtask

    task automatic t_fall();
        slow <= 1'b1;
        wait_lock(1'b0, 20000);
        cyc(2);
        check(lock_status, 1'b0, "lock lost");
        check(event_request[FLG_FALL], 1'b1, "fall request");
        flag_clear <= 3'h6;
        irq_enable_set <= 3'h7;
        irq_enable_clear <= 3'h7;
        cyc(1);
        {flag_clear, irq_enable_set, irq_enable_clear} <= 9'h000;
        cyc(2);
        check(event_flags & 3'h6, 3'h0, "flags cleared");
        check(irq_enables, 3'h0, "clear wins");
        slow <= 1'b0;
    endtask

    task automatic t_timeout();
        lock_timer_use <= 1'b1;
        start(FDP_REF_GCLK, 8'h00, 12'hFA0);
        cyc(100);
        check(event_flags[FLG_TIMEOUT], 1'b0, "early timeout");
        cyc(150);
        check(event_flags[FLG_TIMEOUT], 1'b1, "timeout");
        loop_enable <= 1'b0;
        cyc(6);
        check({lock_status, pll_output_clock}, 2'h0, "stopped");
    endtask

    task automatic test_done();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Whole sequence needs well under 95000 cycles
    initial begin
        #950_000;
        fails++;
        test_done();
    end

    initial begin
        run <= 1'b1;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        cyc(4);
        t_reset();
        t_refs();
        t_gate();
        t_lock();
        t_fall();
        t_timeout();
        test_done();
    end
endmodule
